// ### hw/conv_cfg_map.vh
// Register offsets, field positions, reset values and counts of the slice
`ifndef CONV_CFG_MAP_VH
`define CONV_CFG_MAP_VH

// Register offsets (15-bit serial port address)
`define OFS_NUM_BYTE3 15'h012D
`define OFS_NUM_BYTE4 15'h012E
`define OFS_NUM_BYTE5 15'h012F
`define OFS_CHK_CTRL 15'h014B
`define OFS_REAL_ERR 15'h014C
`define OFS_IMAG_ERR 15'h014D
`define OFS_SHUFFLE 15'h0151
`define OFS_DECODE 15'h0152
`define OFS_STRENGTH 15'h01DF
`define OFS_RX_GLOBAL 15'h0200
`define OFS_LANE_MASK 15'h0201

// Checker control and status field positions
`define BIT_IMAG_OK 7
`define BIT_REAL_OK 6
`define BIT_IMAG_INV 4
`define BIT_REAL_INV 3
`define BIT_POLY 2
`define BIT_CNT_CLEAR 1
`define BIT_CHK_EN 0

// Reset values
`define RST_NUM_BYTE 8'h00
`define RST_REAL_INV 1'b0
`define RST_IMAG_INV 1'b1
`define RST_POLY 1'b0
`define RST_CNT_CLEAR 1'b0
`define RST_CHK_EN 1'b0
`define RST_ERR_CNT 8'h00
`define RST_SHUFFLE 1'b0
`define RST_DECODE 2'h0
`define RST_STRENGTH 4'hF
`define RST_SLEW 2'h3
`define RST_DRIVE 2'h3
`define RST_RX_GLOBAL 1'b1
`define RST_LANE_MASK 8'h00

// Decode code that is reserved and refused
`define DECODE_RESERVED 2'h3

// Consecutive matches before a channel reports a good sequence
`define GOOD_RUN 4'hF

// Largest error count; a counter holds here instead of wrapping
`define ERR_CNT_MAX 8'hFF

// Serial frame layout: 16 instruction bits, then 8-bit data bytes
`define LAST_INSTR_BIT 5'h0F
`define FIRST_DATA_BIT 5'h10
`define LAST_DATA_BIT 5'h17

`endif

// ### hw/conv_cfg_regs.v
// Converter configuration slice: serial port, registers, sequence checker
//
// How it works
// - Upper three numerator bytes at 0x12D..0x12F, one value for all words.
// - Numerator pairs with the one shared modulus held from 0x124.
// - Bit 7 reads 1 while imaginary checker sees the right sequence.
// - Bit 6 reads 1 while real checker sees the right sequence.
// - Inversion bits: real bit 3 resets 0, imaginary resets 1.
// - Bit 2 picks x^7+x^6+1 when 0, x^15+x^14+1 when 1.
// - Bit 1 set clears and holds both error counters.
// - Bit 0 enables the checker, reset value 0.
// - Real error count readable at 0x14C, resets to zero.
// - Imaginary error count kept apart, readable, resets to zero.
// - Shuffle control at 0x151 enables MSB shuffling, reset 0.
// - Decode field at 0x152: NRZ, mixing, return-to-zero; 11 reserved.
// - 0x1DF four-bit field: slew low two bits, drive upper two.
// - 0x200 bit 0, reset 1, powers down whole receiver front end.
// - 0x201 bit n powers down receiver lane n, reset 0.
`include "conv_cfg_map.vh"

module conv_cfg_regs (
   input wire CLK,
   input wire RESET_N,
   input wire CS_N,
   input wire SCLK,
   input wire SDI,
   output reg SDO,
   output reg SDO_EN_N,
   input wire SAMPLE_VALID,
   input wire REAL_SAMPLE_BIT,
   input wire IMAG_SAMPLE_BIT,
   output reg [23:0] FRACTION_NUMERATOR_HI,
   output reg MSB_SHUFFLE_EN,
   output reg [1:0] DECODE_MODE_SEL,
   output reg [1:0] PORT_SLEW,
   output reg [1:0] PORT_DRIVE,
   output reg RECEIVER_GLOBAL_OFF,
   output reg [7:0] LANE_OFF_MASK
);

   // One-hot frame phases
   localparam [2:0] PH_IDLE = 3'h1;
   localparam [2:0] PH_INSTR = 3'h2;
   localparam [2:0] PH_DATA = 3'h4;

   // Serial port state
   reg [2:0] phase_q;
   reg sclk_q;
   reg [4:0] bit_cnt_q;
   reg [15:0] shift_q;
   reg is_read_q;
   reg [14:0] addr_q;
   reg [6:0] tx_q;

   // Register contents
   reg [7:0] num_byte3_q;
   reg [7:0] num_byte4_q;
   reg [7:0] num_byte5_q;
   reg real_inv_q;
   reg imag_inv_q;
   reg poly_q;
   reg cnt_clear_q;
   reg chk_en_q;
   reg shuffle_q;
   reg [1:0] decode_q;
   reg [3:0] strength_q;
   reg rx_global_q;
   reg [7:0] lane_mask_q;

   // Checker results per channel, index 0 real, 1 imaginary
   wire [1:0] seq_ok;
   wire [15:0] err_cnt;
   wire [1:0] ch_bit;
   wire [1:0] ch_inv;

   wire sclk_rise;
   wire sclk_fall;
   wire byte_done;
   wire sdo_step;
   wire [7:0] wr_byte;
   reg [7:0] rd_mux;

   assign sclk_rise = ~CS_N & SCLK & ~sclk_q;
   assign sclk_fall = ~CS_N & ~SCLK & sclk_q;
   assign byte_done = sclk_rise & (bit_cnt_q == `LAST_DATA_BIT);
   assign sdo_step = sclk_fall & is_read_q & (phase_q == PH_DATA);
   assign wr_byte = {shift_q[6:0], SDI};
   assign ch_bit = {IMAG_SAMPLE_BIT, REAL_SAMPLE_BIT};
   assign ch_inv = {imag_inv_q, real_inv_q};

   // Edge memory of the sampled serial clock
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= SCLK;
      end
   end

   // Frame sequencing: instruction, then bytes with address increment
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         bit_cnt_q <= 5'h00;
         shift_q <= 16'h0000;
         is_read_q <= 1'b0;
         addr_q <= 15'h0000;
      end else if (CS_N) begin
         bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[14:0], SDI};
         if (bit_cnt_q == `LAST_INSTR_BIT) begin
            is_read_q <= shift_q[14];
            addr_q <= {shift_q[13:0], SDI};
            bit_cnt_q <= `FIRST_DATA_BIT;
         end else if (bit_cnt_q == `LAST_DATA_BIT) begin
            addr_q <= addr_q + 15'h0001;
            bit_cnt_q <= `FIRST_DATA_BIT;
         end else begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
      end
   end

   // Frame phase: idle, instruction bits, then data bytes until deselect
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         phase_q <= PH_IDLE;
      end else if (CS_N) begin
         phase_q <= PH_IDLE;
      end else begin
         case (phase_q)
            PH_IDLE: phase_q <= PH_INSTR;
            PH_INSTR: begin
               if (sclk_rise && bit_cnt_q == `LAST_INSTR_BIT) begin
                  phase_q <= PH_DATA;
               end
            end
            PH_DATA: phase_q <= PH_DATA;
            default: phase_q <= PH_IDLE;
         endcase
      end
   end

   // Read data selected by address; unmapped and reserved bits read zero
   always @* begin
      rd_mux = 8'h00;
      case (addr_q)
         `OFS_NUM_BYTE3: rd_mux = num_byte3_q;
         `OFS_NUM_BYTE4: rd_mux = num_byte4_q;
         `OFS_NUM_BYTE5: rd_mux = num_byte5_q;
         `OFS_CHK_CTRL: begin
            rd_mux[`BIT_IMAG_OK] = seq_ok[1];
            rd_mux[`BIT_REAL_OK] = seq_ok[0];
            rd_mux[`BIT_IMAG_INV] = imag_inv_q;
            rd_mux[`BIT_REAL_INV] = real_inv_q;
            rd_mux[`BIT_POLY] = poly_q;
            rd_mux[`BIT_CNT_CLEAR] = cnt_clear_q;
            rd_mux[`BIT_CHK_EN] = chk_en_q;
         end
         `OFS_REAL_ERR: rd_mux = err_cnt[7:0];
         `OFS_IMAG_ERR: rd_mux = err_cnt[15:8];
         `OFS_SHUFFLE: rd_mux = {7'h00, shuffle_q};
         `OFS_DECODE: rd_mux = {6'h00, decode_q};
         `OFS_STRENGTH: rd_mux = {4'h0, strength_q};
         `OFS_RX_GLOBAL: rd_mux = {7'h00, rx_global_q};
         `OFS_LANE_MASK: rd_mux = lane_mask_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data shifts out MSB first on falling serial clock edges
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SDO <= 1'h0;
         tx_q <= 7'h00;
      end else if (sdo_step) begin
         if (bit_cnt_q == `FIRST_DATA_BIT) begin
            SDO <= rd_mux[7];
            tx_q <= rd_mux[6:0];
         end else begin
            SDO <= tx_q[6];
            tx_q <= {tx_q[5:0], 1'h0};
         end
      end
   end

   // Pin driven from the first read data bit until the frame ends
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SDO_EN_N <= 1'h1;
      end else if (CS_N) begin
         SDO_EN_N <= 1'h1;
      end else if (sdo_step) begin
         SDO_EN_N <= 1'h0;
      end
   end

   // Register writes at the end of each written byte
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         num_byte3_q <= `RST_NUM_BYTE;
         num_byte4_q <= `RST_NUM_BYTE;
         num_byte5_q <= `RST_NUM_BYTE;
         real_inv_q <= `RST_REAL_INV;
         imag_inv_q <= `RST_IMAG_INV;
         poly_q <= `RST_POLY;
         cnt_clear_q <= `RST_CNT_CLEAR;
         chk_en_q <= `RST_CHK_EN;
         shuffle_q <= `RST_SHUFFLE;
         decode_q <= `RST_DECODE;
         strength_q <= `RST_STRENGTH;
         rx_global_q <= `RST_RX_GLOBAL;
         lane_mask_q <= `RST_LANE_MASK;
      end else if (byte_done && !is_read_q) begin
         case (addr_q)
            `OFS_NUM_BYTE3: num_byte3_q <= wr_byte;
            `OFS_NUM_BYTE4: num_byte4_q <= wr_byte;
            `OFS_NUM_BYTE5: num_byte5_q <= wr_byte;
            `OFS_CHK_CTRL: begin
               // Status bits 7, 6 and reserved bit 5 are not written
               imag_inv_q <= wr_byte[`BIT_IMAG_INV];
               real_inv_q <= wr_byte[`BIT_REAL_INV];
               poly_q <= wr_byte[`BIT_POLY];
               cnt_clear_q <= wr_byte[`BIT_CNT_CLEAR];
               chk_en_q <= wr_byte[`BIT_CHK_EN];
            end
            `OFS_SHUFFLE: shuffle_q <= wr_byte[0];
            `OFS_DECODE: begin
               // The reserved code is refused and the old mode kept
               if (wr_byte[1:0] != `DECODE_RESERVED) begin
                  decode_q <= wr_byte[1:0];
               end
            end
            `OFS_STRENGTH: strength_q <= wr_byte[3:0];
            `OFS_RX_GLOBAL: rx_global_q <= wr_byte[0];
            `OFS_LANE_MASK: lane_mask_q <= wr_byte;
            default: begin
               // Read-only and unmapped addresses ignore writes
            end
         endcase
      end
   end

   // Sequence checker, one instance per channel
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : chk
         reg [14:0] hist_q;
         reg [3:0] run_q;
         reg ok_q;
         reg [7:0] cnt_q;
         wire rx;
         wire pred;
         wire mism;

         // Undo expected inversion, then predict from history
         assign rx = ch_bit[ch] ^ ch_inv[ch];
         assign pred = poly_q ? (hist_q[14] ^ hist_q[13]) :
                       (hist_q[6] ^ hist_q[5]);
         assign mism = chk_en_q & SAMPLE_VALID & (rx != pred);

         // Self-seeding history and run of consecutive matches
         always @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               hist_q <= 15'h0000;
               run_q <= 4'h0;
               ok_q <= 1'b0;
            end else if (!chk_en_q) begin
               run_q <= 4'h0;
               ok_q <= 1'b0;
            end else if (SAMPLE_VALID) begin
               hist_q <= {hist_q[13:0], rx};
               if (mism) begin
                  run_q <= 4'h0;
                  ok_q <= 1'b0;
               end else if (run_q != `GOOD_RUN) begin
                  run_q <= run_q + 4'h1;
                  ok_q <= (run_q + 4'h1) == `GOOD_RUN;
               end else begin
                  ok_q <= 1'b1;
               end
            end
         end

         // Saturating error count, cleared and held by the clear bit
         always @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               cnt_q <= `RST_ERR_CNT;
            end else if (cnt_clear_q) begin
               cnt_q <= `RST_ERR_CNT;
            end else if (mism && cnt_q != `ERR_CNT_MAX) begin
               cnt_q <= cnt_q + 8'h01;
            end
         end

         // Per-channel results gathered for the read mux
         assign seq_ok[ch] = ok_q;
         assign err_cnt[ch * 8 +: 8] = cnt_q;
      end
   endgenerate

   // Numerator bits 47..24, used with the shared modulus elsewhere
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FRACTION_NUMERATOR_HI <= {3{`RST_NUM_BYTE}};
      end else begin
         FRACTION_NUMERATOR_HI <=
            {num_byte5_q, num_byte4_q, num_byte3_q};
      end
   end

   // Converter output mode pins
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         MSB_SHUFFLE_EN <= `RST_SHUFFLE;
         DECODE_MODE_SEL <= `RST_DECODE;
      end else begin
         MSB_SHUFFLE_EN <= shuffle_q;
         DECODE_MODE_SEL <= decode_q;
      end
   end

   // Serial port pad slew and drive strength
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PORT_SLEW <= `RST_SLEW;
         PORT_DRIVE <= `RST_DRIVE;
      end else begin
         PORT_SLEW <= strength_q[1:0];
         PORT_DRIVE <= strength_q[3:2];
      end
   end

   // Receiver front end and lane power-down pins
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RECEIVER_GLOBAL_OFF <= `RST_RX_GLOBAL;
         LANE_OFF_MASK <= `RST_LANE_MASK;
      end else begin
         RECEIVER_GLOBAL_OFF <= rx_global_q;
         LANE_OFF_MASK <= lane_mask_q;
      end
   end

endmodule

// ### test/conv_cfg_properties.sv
// Port-level checks for the converter configuration slice
module conv_cfg_properties (
   input wire CLK,
   input wire RESET_N,
   input wire CS_N,
   input wire [23:0] FRACTION_NUMERATOR_HI,
   input wire MSB_SHUFFLE_EN,
   input wire [1:0] DECODE_MODE_SEL,
   input wire [1:0] PORT_SLEW,
   input wire [1:0] PORT_DRIVE,
   input wire RECEIVER_GLOBAL_OFF,
   input wire [7:0] LANE_OFF_MASK
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   // Numerator, lanes, slew, drive and receiver off only move with a selected frame; reserved decode never output
   a_numer_hold:
      assert property (CS_N && $past(CS_N) |-> $stable(FRACTION_NUMERATOR_HI))
         else $error("numerator moved outside a frame");
   a_lane_hold:
      assert property (CS_N [*2] |-> $stable(LANE_OFF_MASK))
         else $error("lane mask moved outside a frame");
   a_drive_moves:
      assert property ($changed({PORT_DRIVE, PORT_SLEW}) |-> !$past(CS_N))
         else $error("slew or drive moved without a frame");
   a_rxoff_moves:
      assert property ($changed(RECEIVER_GLOBAL_OFF) |-> $past(!CS_N))
         else $error("global receiver off moved without a frame");
   a_decode_legal:
      assert property (DECODE_MODE_SEL != 2'h3)
         else $error("reserved decode code reached the output");
   // Values seen at the first edge after reset is released
   a_strength_reset:
      assert property ($rose(RESET_N) |-> PORT_SLEW == 2'h3
         && PORT_DRIVE == 2'h3)
         else $error("slew or drive reset value wrong");
   a_rxoff_reset:
      assert property ($rose(RESET_N) |-> RECEIVER_GLOBAL_OFF
         && LANE_OFF_MASK == 8'h00) else $error("power down reset value wrong");
   a_shuffle_reset:
      assert property ($rose(RESET_N) |-> !MSB_SHUFFLE_EN
         && DECODE_MODE_SEL == 2'h0 && FRACTION_NUMERATOR_HI == 24'h000000)
         else $error("shuffle, decode or numerator reset value wrong");
endmodule

bind conv_cfg_regs conv_cfg_properties props (.CLK(CLK), .RESET_N(RESET_N),
   .CS_N(CS_N), .FRACTION_NUMERATOR_HI(FRACTION_NUMERATOR_HI),
   .MSB_SHUFFLE_EN(MSB_SHUFFLE_EN), .DECODE_MODE_SEL(DECODE_MODE_SEL),
   .PORT_SLEW(PORT_SLEW), .PORT_DRIVE(PORT_DRIVE),
   .RECEIVER_GLOBAL_OFF(RECEIVER_GLOBAL_OFF), .LANE_OFF_MASK(LANE_OFF_MASK));

// ### test/spi_host_model.sv
// Serial port host that runs one instruction plus one data byte per frame
module spi_host_model (
   input wire clk,
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // Data set with the low phase, read data taken at each rise
   task automatic xfer(input logic [15:0] ins, input logic [7:0] wd,
         output logic [7:0] rd);
      logic [23:0] f;
      f = {ins, wd};
      rd = 8'h00;
      @(posedge clk) cs_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk) sclk <= 1'b0;
         sdi <= f[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         if (i < 8) rd[i] = sdo;
         repeat (4) @(posedge clk);
      end
      @(posedge clk) sclk <= 1'b0;
      @(posedge clk) cs_n <= 1'b1;
      sdi <= ~sdi; // Released line shows no stale value
   endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the converter configuration slice
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic valid = 1'b0;
   logic re_bit = 1'b0;
   logic im_bit = 1'b0;
   logic gen_on = 1'b0, poly15 = 1'b0, flip_r = 1'b0, flip_i = 1'b0;
   logic [14:0] lfsr = 15'h0001;
   logic [7:0] rv;
   wire cs_n, sclk, sdi, sdo, sdo_en_n, shuf, rx_off;
   wire [23:0] numer;
   wire [1:0] dec, slew, drv;
   wire [7:0] lanes;
   wire nb = poly15 ? lfsr[14] ^ lfsr[13] : lfsr[6] ^ lfsr[5];
   // Undriven data line reads the inverse, so a missing enable shows up
   wire sdo_line = sdo_en_n ? ~sdo : sdo;
   int n_errors = 0;
   int checks_done = 0;

   initial forever #4 clk = ~clk;
   conv_cfg_regs dut (.CLK(clk), .RESET_N(reset_n), .CS_N(cs_n), .SCLK(sclk),
      .SDI(sdi), .SDO(sdo), .SDO_EN_N(sdo_en_n), .SAMPLE_VALID(valid),
      .REAL_SAMPLE_BIT(re_bit), .IMAG_SAMPLE_BIT(im_bit),
      .FRACTION_NUMERATOR_HI(numer), .MSB_SHUFFLE_EN(shuf),
      .DECODE_MODE_SEL(dec), .PORT_SLEW(slew), .PORT_DRIVE(drv),
      .RECEIVER_GLOBAL_OFF(rx_off), .LANE_OFF_MASK(lanes));
   spi_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .sdo(sdo_line));

   // Sequence source, one word per clock on both channels
   always @(posedge clk) begin
      if (gen_on) begin
         lfsr <= {lfsr[13:0], nb};
         re_bit <= nb ^ flip_r;
         im_bit <= nb ^ flip_i;
      end
      valid <= gen_on;
   end

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: pins %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host.xfer({1'b0, a}, d, rv);
   endtask
   task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
      host.xfer({1'b1, a}, 8'h00, rv);
      chk_reg(rv, exp);
   endtask
   task automatic report_and_stop();
      $display("Checks made: %0d, mismatches: %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic t_reset();
      chk_pin(numer, 24'h000000);
      chk_pin({20'h0, drv, slew}, 24'h00000F);
      chk_pin({15'h0, rx_off, lanes}, 24'h000100);
      rd_chk(15'h014B, 8'h10);
      rd_chk(15'h014D, 8'h00);
      rd_chk(15'h0200, 8'h01);
      $display("reset values test done");
   endtask
   task automatic t_regs();
      wr(15'h012D, 8'hA1);
      wr(15'h012E, 8'hB2);
      wr(15'h012F, 8'hC3);
      chk_pin(numer, 24'hC3B2A1);
      wr(15'h0201, 8'hA5);
      chk_pin({16'h0, lanes}, 24'h0000A5);
      wr(15'h01DF, 8'hF6);
      rd_chk(15'h01DF, 8'h06);
      chk_pin({20'h0, drv, slew}, 24'h000006);
      wr(15'h0200, 8'hFE);
      chk_pin({23'h0, rx_off}, 24'h000000);
      wr(15'h0151, 8'hFF);
      chk_pin({23'h0, shuf}, 24'h000001);
      for (int c = 0; c < 4; c++) begin
         wr(15'h0152, 8'(c));
         chk_pin({22'h0, dec}, c == 3 ? 24'h000002 : 24'(c));
      end
      wr(15'h014C, 8'h55);
      rd_chk(15'h014C, 8'h00);
      rd_chk(15'h0150, 8'h00);
      $display("register test done");
   endtask
   task automatic t_check();
      gen_on <= 1'b1;
      wr(15'h014B, 8'hE1);
      wr(15'h014B, 8'h03);
      wr(15'h014B, 8'h01);
      rd_chk(15'h014B, 8'hC1);
      rd_chk(15'h014C, 8'h00);
      @(posedge clk) flip_i <= 1'b1;
      @(posedge clk) flip_i <= 1'b0;
      rd_chk(15'h014D, 8'h03);
      rd_chk(15'h014C, 8'h00);
      // Inverted real data, then the long polynomial
      flip_r <= 1'b1;
      wr(15'h014B, 8'h09);
      wr(15'h014B, 8'h0B);
      wr(15'h014B, 8'h09);
      rd_chk(15'h014B, 8'hC9);
      poly15 <= 1'b1;
      wr(15'h014B, 8'h0D);
      wr(15'h014B, 8'h0F);
      wr(15'h014B, 8'h0D);
      rd_chk(15'h014B, 8'hCD);
      // Every real word now wrong: count tops out and holds
      flip_r <= 1'b0;
      repeat (300) @(posedge clk);
      rd_chk(15'h014C, 8'hFF);
      rd_chk(15'h014B, 8'h8D);
      wr(15'h014B, 8'h0F);
      rd_chk(15'h014C, 8'h00);
      wr(15'h014B, 8'h0C);
      rd_chk(15'h014B, 8'h0C);
      rd_chk(15'h014C, 8'h00);
      $display("sequence checker test done");
   endtask

   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_regs();
      t_check();
      report_and_stop();
   end
   // Watchdog against a hung frame
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
endmodule
